// File: logic/sdram_pin_command_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_map.svh"

module sdram_pin_command_interface #(
    parameter int DQ_W   = 16,
    parameter int DM_W   = (DQ_W == 16) ? 2 : 1,
    parameter int MEM_AW = 10
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic              en_i,
    input  wire logic              cke_i,
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic [`BA_W-1:0]  ba_i,
    input  wire logic [`ROW_W-1:0] addr_i,
    input  wire logic [DM_W-1:0]   dqm_i,
    input  wire logic [DQ_W-1:0]   dq_i,
    output logic      [DQ_W-1:0]   dq_o,
    output logic      [DQ_W-1:0]   dq_oe_o,
    output logic      [3:0]        bank_open_o,
    output logic      [2:0]        power_state_o,
    output logic                   write_overrun_o
);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    localparam logic [11:0] COL_MASK = (DQ_W == 4) ? 12'h7ff : (DQ_W == 8) ? 12'h3ff : 12'h1ff;
    localparam int PIN_W = 5 + `BA_W + `ROW_W + DM_W + DQ_W;

    // command decode, chip select part of the code
    function automatic sdram_pin_pkg::cmd_e decode(input logic [3:0] c);
        if (c[3])
            return sdram_pin_pkg::CMD_DESEL;
        return sdram_pin_pkg::cmd_e'(c);
    endfunction

    // start column per data width
    function automatic logic [11:0] col_of(input logic [`ROW_W-1:0] a);
        if (DQ_W == 4)
            return {1'h0, a[11], a[9:0]};
        if (DQ_W == 8)
            return {2'h0, a[9:0]};
        return {3'h0, a[8:0]};
    endfunction

    // wrap inside the burst, full page wraps on the row
    function automatic logic [11:0] next_col(input logic [11:0] c, input logic [2:0] bl);
        logic [11:0] m;
        m = (bl == `BL_FULL) ? COL_MASK : ((12'h1 << bl) - 12'h1);
        return (c & ~m) | ((c + 12'h1) & m);
    endfunction

    // storage word index
    function automatic logic [MEM_AW-1:0] mem_idx(input logic [1:0] b, input logic [`ROW_W-1:0] r,
                                                  input logic [11:0] c);
        logic [26:0] f;
        f = {r, b, c};
        return f[MEM_AW-1:0];
    endfunction

    // mask lanes to data bits
    function automatic logic [DQ_W-1:0] lane_bits(input logic [DM_W-1:0] m);
        logic [DQ_W-1:0] r;
        r = '0;
        for (int i = 0; i < DQ_W; i++)
            r[i] = m[(DM_W == 2) ? i / 8 : 0];
        return r;
    endfunction

    // ----------------------------------------
    // reset and pin synchronisers
    // ----------------------------------------
    logic [1:0]       rst_sync_reg;
    logic             rst_n;
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
    assign rst_n = rst_sync_reg[1];

    // pins sampled on rising edge, two stages
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
        end
        else if (en_i)
        begin
            pin_s1_reg <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, ba_i, addr_i, dqm_i, dq_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic              cke_s;
    logic              cs_n_s;
    logic              ras_n_s;
    logic              cas_n_s;
    logic              we_n_s;
    logic [`BA_W-1:0]  ba_s;
    logic [`ROW_W-1:0] a_s;
    logic [DM_W-1:0]   dm_s;
    logic [DQ_W-1:0]   dq_s;
    assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s, dm_s, dq_s} = pin_s2_reg;

    // ----------------------------------------
    // command and current beat
    // ----------------------------------------
    sdram_pin_pkg::pwr_e  pwr_reg;
    sdram_pin_pkg::pwr_e  pwr_next;
    sdram_pin_pkg::cmd_e  cmd_raw;
    sdram_pin_pkg::cmd_e  cmd;
    logic [`ROW_W-1:0]    mode_reg;
    logic [`ROW_W-1:0]    mode_next;
    logic [3:0]           open_reg;
    logic [3:0]           open_next;
    logic [`ROW_W-1:0]    row_reg [4];
    logic [`ROW_W-1:0]    row_next [4];
    logic                 bst_act_reg;
    logic                 bst_act_next;
    logic                 bst_wr_reg;
    logic                 bst_wr_next;
    logic                 bst_ap_reg;
    logic                 bst_ap_next;
    logic [1:0]           bst_bank_reg;
    logic [1:0]           bst_bank_next;
    logic [11:0]          bst_col_reg;
    logic [11:0]          bst_col_next;
    logic [7:0]           bst_left_reg;
    logic [7:0]           bst_left_next;
    logic                 run;
    logic                 new_acc;
    logic                 cur_v;
    logic                 cur_wr;
    logic [1:0]           cur_bank;
    logic [11:0]          cur_col;
    logic [MEM_AW-1:0]    cur_idx;
    logic [2:0]           bl;
    logic                 full_pg;
    logic                 cl_two;

    // internal clock runs only in run state with clock enable high
    assign run = (pwr_reg == sdram_pin_pkg::PWR_RUN) && cke_s;
    assign cmd_raw = decode({cs_n_s, ras_n_s, cas_n_s, we_n_s});
    assign cmd = run ? cmd_raw : sdram_pin_pkg::CMD_DESEL;
    assign bl = mode_reg[`MR_BL_LSB +: 3];
    assign full_pg = (bl == `BL_FULL);
    assign cl_two = (mode_reg[`MR_CL_LSB +: 3] == `CL_TWO);

    // beat 0 comes from the command itself, later beats from the burst state
    assign new_acc = (cmd == sdram_pin_pkg::CMD_RD) || (cmd == sdram_pin_pkg::CMD_WR);
    assign cur_v = new_acc || (run && bst_act_reg && cmd != sdram_pin_pkg::CMD_BST);
    assign cur_wr = new_acc ? (cmd == sdram_pin_pkg::CMD_WR) : bst_wr_reg;
    assign cur_bank = new_acc ? ba_s : bst_bank_reg;
    assign cur_col = new_acc ? col_of(a_s) : bst_col_reg;
    assign cur_idx = mem_idx(cur_bank, row_reg[cur_bank], cur_col);

    // ----------------------------------------
    // control: power, banks, mode, burst
    // ----------------------------------------
    always_comb
    begin
        pwr_next = pwr_reg;
        mode_next = mode_reg;
        open_next = open_reg;
        row_next = row_reg;
        bst_act_next = bst_act_reg;
        bst_wr_next = bst_wr_reg;
        bst_ap_next = bst_ap_reg;
        bst_bank_next = bst_bank_reg;
        bst_col_next = bst_col_reg;
        bst_left_next = bst_left_reg;
        if (run)
        begin
            if (new_acc)
            begin
                bst_wr_next = (cmd == sdram_pin_pkg::CMD_WR);
                bst_ap_next = a_s[`A_AP_BIT];
                bst_bank_next = ba_s;
                bst_col_next = next_col(col_of(a_s), bl);
                bst_left_next = (8'h1 << bl) - 8'h1;
                bst_act_next = full_pg || (bl != 3'h0);
                if (!bst_act_next && a_s[`A_AP_BIT])
                    open_next[ba_s] = 1'h0;
            end
            else if (cur_v)
            begin
                bst_col_next = next_col(bst_col_reg, bl);
                bst_left_next = bst_left_reg - 8'h1;
                if (!full_pg && bst_left_reg == 8'h1)
                begin
                    bst_act_next = 1'h0;
                    if (bst_ap_reg)
                        open_next[bst_bank_reg] = 1'h0;
                end
            end
            else if (cmd == sdram_pin_pkg::CMD_BST)
                bst_act_next = 1'h0;
            case (cmd)
                sdram_pin_pkg::CMD_ACT:
                begin
                    open_next[ba_s] = 1'h1;
                    row_next[ba_s] = a_s;
                end
                sdram_pin_pkg::CMD_PRE:
                begin
                    if (a_s[`A_AP_BIT])
                        open_next = 4'h0;
                    else
                        open_next[ba_s] = 1'h0;
                end
                sdram_pin_pkg::CMD_LMR:
                    mode_next = a_s;
                sdram_pin_pkg::CMD_RD, sdram_pin_pkg::CMD_WR, sdram_pin_pkg::CMD_BST,
                sdram_pin_pkg::CMD_NOP, sdram_pin_pkg::CMD_REF, sdram_pin_pkg::CMD_DESEL: ;
            endcase
        end
        // clock enable low picks the low-power state
        unique case (pwr_reg)
            sdram_pin_pkg::PWR_RUN:
            begin
                if (!cke_s)
                begin
                    if (bst_act_reg)
                        pwr_next = sdram_pin_pkg::PWR_SUSPEND;
                    else if (cmd_raw == sdram_pin_pkg::CMD_REF && open_reg == 4'h0)
                        pwr_next = sdram_pin_pkg::PWR_SELF;
                    else if (open_reg != 4'h0)
                        pwr_next = sdram_pin_pkg::PWR_PDN_ACT;
                    else
                        pwr_next = sdram_pin_pkg::PWR_PDN_PRE;
                end
            end
            default:
            begin
                if (cke_s)
                    pwr_next = sdram_pin_pkg::PWR_RUN;
            end
        endcase
    end

    // control registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwr_reg <= sdram_pin_pkg::PWR_RUN;
            mode_reg <= `MR_RST;
            open_reg <= 4'h0;
            row_reg <= '{default: '0};
            bst_act_reg <= 1'h0;
            bst_wr_reg <= 1'h0;
            bst_ap_reg <= 1'h0;
            bst_bank_reg <= 2'h0;
            bst_col_reg <= 12'h000;
            bst_left_reg <= 8'h00;
        end
        else if (en_i)
        begin
            pwr_reg <= pwr_next;
            mode_reg <= mode_next;
            open_reg <= open_next;
            row_reg <= row_next;
            bst_act_reg <= bst_act_next;
            bst_wr_reg <= bst_wr_next;
            bst_ap_reg <= bst_ap_next;
            bst_bank_reg <= bst_bank_next;
            bst_col_reg <= bst_col_next;
            bst_left_reg <= bst_left_next;
        end
    end

    // ----------------------------------------
    // write buffer, two entries
    // ----------------------------------------
    logic [DQ_W-1:0]   mem [2**MEM_AW];
    logic [DQ_W-1:0]   bd_reg [2];
    logic [DQ_W-1:0]   bd_next [2];
    logic [DQ_W-1:0]   bm_reg [2];
    logic [DQ_W-1:0]   bm_next [2];
    logic [MEM_AW-1:0] bi_reg [2];
    logic [MEM_AW-1:0] bi_next [2];
    logic              wp_reg;
    logic              wp_next;
    logic              rp_reg;
    logic              rp_next;
    logic [1:0]        cnt_reg;
    logic [1:0]        cnt_next;
    logic              ovr_next;
    logic              in_v;
    logic              in_rdy;
    logic              out_rdy;
    logic              drain;

    // array port busy with a read beat stalls the drain
    always_comb
    begin
        in_v = cur_v && cur_wr;
        in_rdy = (cnt_reg != 2'h2);
        out_rdy = !(cur_v && !cur_wr);
        drain = (cnt_reg != 2'h0) && out_rdy;
        bd_next = bd_reg;
        bm_next = bm_reg;
        bi_next = bi_reg;
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        ovr_next = in_v && !in_rdy;
        if (in_v && in_rdy)
        begin
            bd_next[wp_reg] = dq_s;
            bm_next[wp_reg] = lane_bits(dm_s);
            bi_next[wp_reg] = cur_idx;
            wp_next = !wp_reg;
        end
        if (drain)
            rp_next = !rp_reg;
        cnt_next = cnt_reg + 2'((in_v && in_rdy) ? 1 : 0) - 2'(drain ? 1 : 0);
    end

    // buffer registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bd_reg <= '{default: '0};
            bm_reg <= '{default: '0};
            bi_reg <= '{default: '0};
            wp_reg <= 1'h0;
            rp_reg <= 1'h0;
            cnt_reg <= 2'h0;
            write_overrun_o <= 1'h0;
        end
        else if (en_i)
        begin
            bd_reg <= bd_next;
            bm_reg <= bm_next;
            bi_reg <= bi_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            write_overrun_o <= ovr_next;
        end
    end

    // masked bits keep their stored value
    always_ff @(posedge clk_i)
    begin
        if (en_i && drain)
            mem[bi_reg[rp_reg]] <= (mem[bi_reg[rp_reg]] & bm_reg[rp_reg])
                                 | (bd_reg[rp_reg] & ~bm_reg[rp_reg]);
    end

    // ----------------------------------------
    // read path: latency pipe and output enable
    // ----------------------------------------
    logic [DQ_W-1:0] p0_reg;
    logic [DQ_W-1:0] p0_next;
    logic [DQ_W-1:0] p1_reg;
    logic [DQ_W-1:0] p1_next;
    logic            p0v_reg;
    logic            p0v_next;
    logic            p1v_reg;
    logic            p1v_next;
    logic [DM_W-1:0] dmp_reg [`RD_HIZ_LAT-1];
    logic [DM_W-1:0] dmp_next [`RD_HIZ_LAT-1];
    logic [DQ_W-1:0] dq_next;
    logic [DQ_W-1:0] oe_next;

    // frozen while the internal clock is off
    always_comb
    begin
        p0_next = p0_reg;
        p1_next = p1_reg;
        p0v_next = p0v_reg;
        p1v_next = p1v_reg;
        dmp_next = dmp_reg;
        dq_next = dq_o;
        oe_next = dq_oe_o;
        if (run)
        begin
            p0_next = mem[cur_idx];
            p0v_next = cur_v && !cur_wr;
            p1_next = p0_reg;
            p1v_next = p0v_reg;
            dmp_next[0] = dm_s;
            for (int i = 1; i < `RD_HIZ_LAT - 1; i++)
                dmp_next[i] = dmp_reg[i-1];
            dq_next = cl_two ? p0_reg : p1_reg;
            oe_next = lane_bits(~dmp_reg[`RD_HIZ_LAT-2])
                    & {DQ_W{cl_two ? p0v_reg : p1v_reg}};
        end
    end

    // read registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            p0_reg <= '0;
            p1_reg <= '0;
            p0v_reg <= 1'h0;
            p1v_reg <= 1'h0;
            dmp_reg <= '{default: '0};
            dq_o <= '0;
            dq_oe_o <= '0;
        end
        else if (en_i)
        begin
            p0_reg <= p0_next;
            p1_reg <= p1_next;
            p0v_reg <= p0v_next;
            p1v_reg <= p1v_next;
            dmp_reg <= dmp_next;
            dq_o <= dq_next;
            dq_oe_o <= oe_next;
        end
    end

    assign bank_open_o = open_reg;
    assign power_state_o = pwr_reg;

endmodule // sdram_pin_command_interface

`default_nettype wire

// File: logic/sdram_pin_map.svh
// Contract
// - every input sampled on rising clock; clock steps burst counter and output registers
// - CKE low stops internal clock: power-down, self refresh or clock suspend
// - CKE synchronous except inside power-down or self refresh; inputs ignored there
// - chip select high masks new commands; bursts and data masking carry on
// - command decoded from chip select, RAS, CAS and WE together
// - write data with mask high is not stored
// - read data output goes high impedance two clocks after mask high
// - x16 lower mask covers bits 7..0, upper mask bits 15..8
// - two bank inputs pick the bank for activate, read, write, precharge
// - activate captures all thirteen address bits as the open row
// - column from address bits per width: x4, x8 or x16
// - address bit 10 with read or write selects auto precharge
// - precharge with bit 10 high closes all banks, low one bank
// - load mode register takes operating code from the address inputs
// - burst lengths 1, 2, 4, 8 or full page, with burst terminate
`ifndef SDRAM_PIN_MAP_SVH
`define SDRAM_PIN_MAP_SVH
`define MR_BL_LSB 0
`define MR_CL_LSB 4
`define MR_RST 13'h0000
`define BL_FULL 3'h7
`define CL_TWO 3'h2
`define A_AP_BIT 10
`define ROW_W 13
`define BA_W 2
`define COL_W 12
`define RD_HIZ_LAT 2
`endif

// File: logic/sdram_pin_pkg.sv
package sdram_pin_pkg;
    // command code {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_LMR   = 4'h0,
        CMD_REF   = 4'h1,
        CMD_PRE   = 4'h2,
        CMD_ACT   = 4'h3,
        CMD_WR    = 4'h4,
        CMD_RD    = 4'h5,
        CMD_BST   = 4'h6,
        CMD_NOP   = 4'h7,
        CMD_DESEL = 4'hf
    } cmd_e;
    // power states
    typedef enum logic [2:0] {
        PWR_RUN     = 3'h0,
        PWR_SUSPEND = 3'h1,
        PWR_PDN_PRE = 3'h2,
        PWR_PDN_ACT = 3'h3,
        PWR_SELF    = 3'h4
    } pwr_e;
endpackage

// File: test/sdram_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_ctrl_model (
    input  wire logic        clk_i,
    output logic             cke_o,
    output logic [3:0]       cmd_o,
    output logic [1:0]       ba_o,
    output logic [12:0]      addr_o,
    output logic [1:0]       dqm_o,
    output logic [15:0]      dq_o
);
    // idle pins from time zero, clock enable held high
    initial
    begin
        cke_o  = 1'b1;
        cmd_o  = sdram_pin_pkg::CMD_NOP;
        ba_o   = 2'h0;
        addr_o = 13'h0000;
        dqm_o  = 2'h0;
        dq_o   = 16'h0000;
    end

    // one command cycle at the next falling edge
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [1:0] m, input logic [15:0] d);
        @(negedge clk_i);
        cmd_o  = c;
        ba_o   = b;
        addr_o = a;
        dqm_o  = m;
        dq_o   = d;
    endtask

    // no-op cycles; released data bus keeps changing
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge clk_i);
            cmd_o = sdram_pin_pkg::CMD_NOP;
            dqm_o = 2'h0;
            dq_o  = ~dq_o;
        end
    endtask

    // clock enable change at the next falling edge
    task automatic set_cke(input logic v);
        @(negedge clk_i);
        cke_o = v;
    endtask
endmodule // sdram_ctrl_model

`default_nettype wire

// File: test/sdram_pin_command_interface_props.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_pin_command_interface_props #(
    parameter int DQ_W = 16,
    parameter int DM_W = 2
) (
    input wire logic            clk_i,
    input wire logic            resetn_i,
    input wire logic            en_i,
    input wire logic            cke_i,
    input wire logic            cs_n_i,
    input wire logic            ras_n_i,
    input wire logic            cas_n_i,
    input wire logic            we_n_i,
    input wire logic [1:0]      ba_i,
    input wire logic [12:0]     addr_i,
    input wire logic [DM_W-1:0] dqm_i,
    input wire logic [DQ_W-1:0] dq_i,
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic [DQ_W-1:0] dq_oe_o,
    input wire logic [3:0]      bank_open_o,
    input wire logic [2:0]      power_state_o,
    input wire logic            write_overrun_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ----------------------------------------
    // pin command history
    // ----------------------------------------
    logic [3:0] cmd_w;
    logic [3:0] act_reg;
    logic [3:0] pre_all_reg;
    assign cmd_w = {cs_n_i, ras_n_i, cas_n_i, we_n_i};

    // shift in activate and precharge-all seen at the pins
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            act_reg     <= 4'h0;
            pre_all_reg <= 4'h0;
        end
        else
        begin
            act_reg     <= {act_reg[2:0], cmd_w == sdram_pin_pkg::CMD_ACT};
            pre_all_reg <= {pre_all_reg[2:0], cmd_w == sdram_pin_pkg::CMD_PRE && addr_i[10]};
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_dqm_lo;
        cke_i && en_i && dqm_i[0] && $past(cke_i) && $past(cke_i, 2) && $past(cke_i, 3)
            ##1 (cke_i && en_i)[*4] |-> dq_oe_o[7:0] == 8'h00;
    endproperty
    a_dqm_lo: assert property (p_dqm_lo) else $error("low lane driven after mask");

    property p_dqm_hi;
        cke_i && en_i && dqm_i[1] && $past(cke_i) && $past(cke_i, 2) && $past(cke_i, 3)
            ##1 (cke_i && en_i)[*4] |-> dq_oe_o[15:8] == 8'h00;
    endproperty
    a_dqm_hi: assert property (p_dqm_hi) else $error("high lane driven after mask");

    property p_lanes;
        dq_oe_o[7:0] inside {8'h00, 8'hff} && dq_oe_o[15:8] inside {8'h00, 8'hff};
    endproperty
    a_lanes: assert property (p_lanes) else $error("drive enable split inside a lane");

    property p_pwr_in;
        power_state_o != sdram_pin_pkg::PWR_RUN && $past(power_state_o) == sdram_pin_pkg::PWR_RUN
            |-> !$past(cke_i, 2) || !$past(cke_i, 3) || !$past(cke_i, 4);
    endproperty
    a_pwr_in: assert property (p_pwr_in) else $error("low power without clock enable low");

    property p_pwr_out;
        power_state_o == sdram_pin_pkg::PWR_RUN && $past(power_state_o) != sdram_pin_pkg::PWR_RUN
            |-> $past(cke_i, 2) || $past(cke_i, 3) || $past(cke_i, 4) || $past(cke_i, 5);
    endproperty
    a_pwr_out: assert property (p_pwr_out) else $error("low power left without clock enable");

    property p_pd_quiet;
        power_state_o > sdram_pin_pkg::PWR_SUSPEND |-> dq_oe_o == '0;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("data driven in power down");

    property p_bank_rise;
        |(bank_open_o & ~$past(bank_open_o)) |-> |act_reg[3:1];
    endproperty
    a_bank_rise: assert property (p_bank_rise) else $error("bank opened without activate");

    property p_bank_all;
        $countones($past(bank_open_o) & ~bank_open_o) > 1 |-> |pre_all_reg[3:1];
    endproperty
    a_bank_all: assert property (p_bank_all) else $error("banks closed without precharge all");

    c_read: cover property (dq_oe_o == 16'hffff);
    c_pdn_pre: cover property (power_state_o == sdram_pin_pkg::PWR_PDN_PRE);
    c_pdn_act: cover property (power_state_o == sdram_pin_pkg::PWR_PDN_ACT);
endmodule // sdram_pin_command_interface_props

bind sdram_pin_command_interface sdram_pin_command_interface_props #(
    .DQ_W(DQ_W),
    .DM_W(DM_W)
) i_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .en_i(en_i), .cke_i(cke_i),
    .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
    .ba_i(ba_i), .addr_i(addr_i), .dqm_i(dqm_i), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .bank_open_o(bank_open_o), .power_state_o(power_state_o),
    .write_overrun_o(write_overrun_o)
);

`default_nettype wire

// File: test/sdram_pin_command_interface_test.sv
`timescale 1ns/1ps
`default_nettype none

module sdram_pin_command_interface_test;
    logic        clk;
    logic        resetn;
    logic        en;
    logic        cke;
    logic [3:0]  cmd;
    logic [1:0]  ba;
    logic [12:0] addr;
    logic [1:0]  dqm;
    logic [15:0] dq_w;
    logic [15:0] dq_r;
    logic [15:0] oe;
    logic [3:0]  bank;
    logic [2:0]  pwr;
    logic        ovr;
    int          num_errors;
    int          comparisons;
    int          cycles;

    sdram_ctrl_model i_ctl (
        .clk_i(clk), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(dq_w)
    );

    sdram_pin_command_interface i_dut (
        .clk_i(clk), .resetn_i(resetn), .en_i(en), .cke_i(cke),
        .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
        .ba_i(ba), .addr_i(addr), .dqm_i(dqm), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(oe),
        .bank_open_o(bank), .power_state_o(pwr), .write_overrun_o(ovr)
    );

    // ----------------------------------------
    // clock, timeout, report
    // ----------------------------------------
    always #5 clk = ~clk;

    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------
    // bus tasks; reads and writes on bank one
    // ----------------------------------------
    task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        i_ctl.cmd(c, b, a, 2'h0, 16'h0000);
    endtask
    task automatic wr(input logic [9:0] col, input logic [1:0] m, input logic [15:0] d, input int n);
        i_ctl.cmd(sdram_pin_pkg::CMD_WR, 2'h1, {3'h0, col}, m, d);
        for (int i = 1; i < n; i++)
            i_ctl.cmd(sdram_pin_pkg::CMD_NOP, 2'h0, 13'h0000, m, d + 16'(i));
        i_ctl.idle(3);
    endtask
    task automatic rd(input logic [9:0] col, input logic [1:0] m, input int n,
                      input logic [15:0] d, input logic [15:0] oe_exp);
        int w = 0;
        i_ctl.cmd(sdram_pin_pkg::CMD_RD, 2'h1, {3'h0, col}, m, 16'h0000);
        i_ctl.idle(1);
        while (oe === 16'h0000 && w < 10)
        begin
            @(negedge clk);
            w++;
        end
        for (int i = 0; i < n; i++)
        begin
            check("read enable", oe, oe_exp);
            check("read data", dq_r & oe_exp, (d + 16'(i)) & oe_exp);
            @(negedge clk);
        end
        i_ctl.idle(2);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_cs_mask();
        op(4'hb, 2'h2, 13'h0abc); // activate with chip deselected
        op(sdram_pin_pkg::CMD_ACT, 2'h1, 13'h1abc);
        i_ctl.idle(6);
        check("bank open", 16'(bank), 16'h0002);
    endtask
    task automatic t_data();
        wr(10'h005, 2'h0, 16'ha5c3, 1);
        wr(10'h006, 2'h0, 16'h1234, 1);
        wr(10'h006, 2'h1, 16'hffff, 1);
        rd(10'h005, 2'h0, 1, 16'ha5c3, 16'hffff);
        rd(10'h205, 2'h0, 1, 16'ha5c3, 16'hffff);
        rd(10'h006, 2'h0, 1, 16'hff34, 16'hffff);
        rd(10'h005, 2'h2, 1, 16'ha5c3, 16'h00ff);
    endtask
    task automatic t_burst();
        op(sdram_pin_pkg::CMD_LMR, 2'h0, 13'h0022);
        i_ctl.idle(3);
        wr(10'h008, 2'h0, 16'h1000, 4);
        rd(10'h008, 2'h0, 4, 16'h1000, 16'hffff);
        op(sdram_pin_pkg::CMD_LMR, 2'h0, 13'h0020);
        i_ctl.idle(3);
    endtask
    task automatic t_pre();
        op(sdram_pin_pkg::CMD_ACT, 2'h3, 13'h0011);
        op(sdram_pin_pkg::CMD_PRE, 2'h1, 13'h0000);
        i_ctl.idle(6);
        check("bank single", 16'(bank), 16'h0008);
        op(sdram_pin_pkg::CMD_ACT, 2'h0, 13'h0022);
        op(sdram_pin_pkg::CMD_ACT, 2'h2, 13'h0033);
        i_ctl.idle(6);
        check("bank three", 16'(bank), 16'h000d);
        op(sdram_pin_pkg::CMD_PRE, 2'h0, 13'h0400);
        i_ctl.idle(6);
        check("bank all", 16'(bank), 16'h0000);
    endtask
    task automatic t_power();
        i_ctl.set_cke(1'b0);
        i_ctl.idle(6);
        check("idle power", 16'(pwr), 16'(sdram_pin_pkg::PWR_PDN_PRE));
        i_ctl.set_cke(1'b1);
        i_ctl.idle(6);
        check("wake", 16'(pwr), 16'(sdram_pin_pkg::PWR_RUN));
        op(sdram_pin_pkg::CMD_ACT, 2'h0, 13'h0044);
        i_ctl.idle(4);
        i_ctl.set_cke(1'b0);
        i_ctl.idle(6);
        check("active power", 16'(pwr), 16'(sdram_pin_pkg::PWR_PDN_ACT));
        i_ctl.set_cke(1'b1);
        i_ctl.idle(6);
        check("bank kept", 16'(bank), 16'h0001);
    endtask
    task automatic t_auto();
        op(sdram_pin_pkg::CMD_RD, 2'h0, 13'h0400); // read with auto precharge
        i_ctl.idle(4);
        en = 1'b0;
        op(sdram_pin_pkg::CMD_ACT, 2'h0, 13'h0055);
        i_ctl.idle(3);
        en = 1'b1;
        check("auto close", 16'(bank), 16'h0000);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        en = 1'b1;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        i_ctl.idle(4);
        check("reset state", {oe[11:0], bank}, 16'h0000);
        op(sdram_pin_pkg::CMD_LMR, 2'h0, 13'h0020);
        i_ctl.idle(3);
        t_cs_mask();
        t_data();
        t_burst();
        t_pre();
        t_power();
        t_auto();
        check("overrun", 16'(ovr), 16'h0000);
        wrap_up();
    end
endmodule // sdram_pin_command_interface_test

`default_nettype wire
